// [pbsp_pkg.sv]
// shared constants and types of the pipelined burst sram port
package pbsp_pkg;
  localparam int ADDR_W      = 17;
  localparam int DATA_W      = 32;
  localparam int LANES       = 4;
  localparam int LANE_W      = 8;
  localparam int WORD_W      = 36;
  localparam int DEPTH       = 131072;
  localparam int BURST_W     = 2;
  localparam logic [1:0] BURST_ONE = 2'h1;
  localparam logic [1:0] SLEEP_CYCLES = 2'h2;
  typedef enum logic {PBSP_LINEAR, PBSP_INTERLEAVED} pbsp_order_t;
endpackage : pbsp_pkg

// [pbsp_mem.sv]
// byte-lane writable storage array with registered read data
`timescale 1ns/10ps
module pbsp_mem (
  // clock
  input  wire logic                          clk,
  // read port
  input  wire logic                          rd_en,
  input  wire logic [pbsp_pkg::ADDR_W-1:0]   rd_addr,
  output logic      [pbsp_pkg::WORD_W-1:0]   rd_data_q,
  // write port
  input  wire logic [pbsp_pkg::LANES-1:0]    wr_lane,
  input  wire logic [pbsp_pkg::ADDR_W-1:0]   wr_addr,
  input  wire logic [pbsp_pkg::WORD_W-1:0]   wr_data
);
  localparam int LW = pbsp_pkg::LANE_W + 1;
  logic [pbsp_pkg::WORD_W-1:0] mem [pbsp_pkg::DEPTH];

  // each lane is nine bits: a data byte with its parity bit
  always_ff @(posedge clk) begin
    for (int i = 0; i < pbsp_pkg::LANES; i++) begin
      if (wr_lane[i]) begin
        mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule : pbsp_mem

// [pbsp_port.sv]
// synchronous port logic of a pipelined burst sram with common data i/o
// Operation
// - clock qualifier high freezes the burst, pipeline and output registers; sleep counter and order strap latch keep running
// - qualifier high stretches the cycle and does not deselect
// - sleep input high enters sleep, memory contents kept
// - input data lines captured into data register on clock rise
// - read drives the word at the address sampled at read start
// - output drive enable high tristates data and parity lines
// - tristate during write data phase, first cycle after deselect, deselected
// - parity lines behave like data, written under their lane strobe
// - order strap low gives linear, high gives interleaved burst order
// - synchronous inputs registered on rising edge only when qualified
// - read data passes through output registers
// - all selects active, qualifier low, load low starts access
// - write strobe picks read or write; lane strobes limit bytes
// - reads, writes, deselects pipelined with fixed latency
// - writes self-timed inside, no write pulse from controller
// - advance high with qualifier low steps the burst counter
// - select a and c active low, select b active high
// - lane strobe writes its byte only with write strobe active; burst beats write under the write type held from the load
`timescale 1ns/10ps
module pbsp_port (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                reset_n,
  // control inputs
  input  wire logic                                clock_qualify_n,
  input  wire logic                                select_a_n,
  input  wire logic                                select_b,
  input  wire logic                                select_c_n,
  input  wire logic                                advance_or_load,
  input  wire logic                                write_n,
  input  wire logic [pbsp_pkg::LANES-1:0]          lane_write_n,
  input  wire logic [pbsp_pkg::ADDR_W-1:0]         address,
  input  wire logic                                output_enable_n,
  input  wire logic                                sleep_request,
  input  wire logic                                burst_order,
  // data lines
  input  wire logic [pbsp_pkg::DATA_W-1:0]         data_in,
  output logic      [pbsp_pkg::DATA_W-1:0]         data_out,
  output logic                                     data_oe,
  // parity lines
  input  wire logic [pbsp_pkg::LANES-1:0]          parity_lines_in,
  output logic      [pbsp_pkg::LANES-1:0]          parity_lines_out,
  output logic                                     parity_lines_oe,
  // status
  output logic                                     sleeping
);
  localparam int LW = pbsp_pkg::LANE_W + 1;

  // burst address from start value and count
  function automatic logic [1:0] burst_next(input logic [1:0] start, input logic [1:0] cnt,
                                            input logic interleave);
    burst_next = interleave ? (start ^ cnt) : 2'(start + cnt);
  endfunction : burst_next

  // pack data and parity lanes into nine-bit lanes
  function automatic logic [pbsp_pkg::WORD_W-1:0] pack(input logic [pbsp_pkg::DATA_W-1:0] d,
                                                       input logic [pbsp_pkg::LANES-1:0] p);
    pack = '0;
    for (int i = 0; i < pbsp_pkg::LANES; i++) begin
      pack[i*LW +: LW] = {p[i], d[i*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W]};
    end
  endfunction : pack

  logic                           run;
  logic                           selected;
  logic                           start;
  logic                           adv;
  // stage 1: access issued at this edge
  logic                           s1_valid_q;
  logic                           s1_write_q;
  logic [pbsp_pkg::LANES-1:0]     s1_lane_q;
  logic [pbsp_pkg::ADDR_W-1:0]    s1_addr_q;
  // stage 2: data phase
  logic                           s2_valid_q;
  logic                           s2_write_q;
  logic [pbsp_pkg::LANES-1:0]     s2_lane_q;
  logic [pbsp_pkg::ADDR_W-1:0]    s2_addr_q;
  // burst state
  logic [pbsp_pkg::ADDR_W-1:0]    base_q;
  logic [1:0]                     count_q;
  logic                           write_hold_q;
  logic                           active_q;
  logic                           emerge_q;
  logic                           mode_q;
  logic                           mode_caught_q;
  logic [1:0]                     sleep_cnt_q;
  logic                           sleeping_q;
  logic [pbsp_pkg::WORD_W-1:0]    rd_word;
  logic [pbsp_pkg::ADDR_W-1:0]    cur_addr;
  logic [1:0]                     next_cnt;
  logic                           drive;
  logic                           rd_en;
  logic [pbsp_pkg::LANES-1:0]     wr_lane;

  assign run = !clock_qualify_n && !sleeping_q;
  assign selected = !select_a_n && select_b && !select_c_n;
  assign start = run && selected && !advance_or_load;
  // burst advance ignores selects and write strobe
  assign adv = run && advance_or_load && active_q;
  assign next_cnt = 2'(count_q + pbsp_pkg::BURST_ONE);
  assign cur_addr = start ? address
                  : {base_q[pbsp_pkg::ADDR_W-1:2],
                     burst_next(base_q[1:0], next_cnt, mode_q)};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q        <= 1'b1;
      mode_caught_q <= 1'b0;
    end else if (!mode_caught_q) begin
      mode_q        <= burst_order;
      mode_caught_q <= 1'b1;
    end
  end

  // sleep entry and exit take two cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_cnt_q <= 2'h0;
      sleeping_q  <= 1'b0;
    end else if (sleep_request != sleeping_q) begin
      if (sleep_cnt_q == pbsp_pkg::SLEEP_CYCLES - 2'h1) begin
        sleeping_q  <= sleep_request;
        sleep_cnt_q <= 2'h0;
      end else begin
        sleep_cnt_q <= 2'(sleep_cnt_q + 2'h1);
      end
    end else begin
      sleep_cnt_q <= 2'h0;
    end
  end

  // burst counter and held write type
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q       <= '0;
      count_q      <= 2'h0;
      write_hold_q <= 1'b0;
      active_q     <= 1'b0;
    end else if (start) begin
      base_q       <= address;
      count_q      <= 2'h0;
      write_hold_q <= !write_n;
      active_q     <= 1'b1;
    end else if (adv) begin
      count_q <= next_cnt;
    end else if (run && !advance_or_load) begin
      active_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_valid_q <= 1'b0;
      s1_write_q <= 1'b0;
      s1_lane_q  <= '0;
      s1_addr_q  <= '0;
      s2_valid_q <= 1'b0;
      s2_write_q <= 1'b0;
      s2_lane_q  <= '0;
      s2_addr_q  <= '0;
    end else if (run) begin
      s1_valid_q <= start || adv;
      s1_write_q <= start ? !write_n : write_hold_q;
      s1_lane_q  <= ~lane_write_n;
      s1_addr_q  <= cur_addr;
      s2_valid_q <= s1_valid_q;
      s2_write_q <= s1_write_q;
      s2_lane_q  <= s1_lane_q;
      s2_addr_q  <= s1_addr_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      emerge_q <= 1'b0;
    end else if (run) begin
      emerge_q <= !s1_valid_q && (start || adv);
    end
  end

  // reads fetched at issue so the output register loads one rise later
  assign rd_en = run && (start || adv) && !(start ? !write_n : write_hold_q);
  // write lands from stage 2, same bus cycle as a read data phase
  // lane strobes only count for a live write beat
  assign wr_lane = (run && s2_valid_q && s2_write_q) ? s2_lane_q : '0;

  // data captured at second rise, written self-timed
  // limitation: a read issued within two beats of a write to the same
  // word still sees the old word, no forwarding path is kept
  pbsp_mem pbsp_mem_inst (
    .clk       (clk),
    .rd_en     (rd_en),
    .rd_addr   (cur_addr),
    .rd_data_q (rd_word),
    .wr_lane   (wr_lane),
    .wr_addr   (s2_addr_q),
    .wr_data   (pack(data_in, parity_lines_in))
  );

  // output registers, loaded one rise after the access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out         <= '0;
      parity_lines_out <= '0;
    end else if (run && s1_valid_q && !s1_write_q) begin
      for (int i = 0; i < pbsp_pkg::LANES; i++) begin
        data_out[i*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] <= rd_word[i*LW +: pbsp_pkg::LANE_W];
        parity_lines_out[i] <= rd_word[i*LW + pbsp_pkg::LANE_W];
      end
    end
  end

  logic out_valid_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
    end else if (run) begin
      out_valid_q <= s1_valid_q && !s1_write_q;
    end
  end

  // drive only for a read data phase
  assign drive = out_valid_q && !output_enable_n && !sleeping_q && !emerge_q;
  assign data_oe         = drive;
  assign parity_lines_oe = drive;
  assign sleeping        = sleeping_q;

  // checks
  // qualifier only stretches
  chk_hold_freeze: assert property (@(posedge clk) disable iff (!reset_n)
    clock_qualify_n |=> $stable(s1_valid_q) && $stable(data_out) && $stable(count_q))
    else $error("state changed while clock qualifier high");
  chk_read_latency: assert property (@(posedge clk) disable iff (!reset_n)
    (start && write_n) ##1 (!clock_qualify_n && !sleeping_q) |=> out_valid_q)
    else $error("read data not valid one cycle after issue");
  chk_write_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (s2_valid_q && s2_write_q) |-> !data_oe)
    else $error("driving during write data phase");
  chk_oe_gates: assert property (@(posedge clk) disable iff (!reset_n)
    output_enable_n |-> !data_oe && !parity_lines_oe)
    else $error("driving with output enable high");
  chk_burst_step: assert property (@(posedge clk) disable iff (!reset_n)
    adv |=> count_q == 2'($past(count_q) + 2'h1))
    else $error("burst counter did not step");
  chk_load_clear: assert property (@(posedge clk) disable iff (!reset_n)
    start |=> count_q == 2'h0 && base_q == $past(address))
    else $error("address not loaded at access start");
  chk_write_hold: assert property (@(posedge clk) disable iff (!reset_n)
    start |=> write_hold_q == !$past(write_n))
    else $error("write type not latched");
  chk_sleep_entry: assert property (@(posedge clk) disable iff (!reset_n)
    sleep_request [*2] |=> sleeping_q)
    else $error("sleep not entered within two cycles");
  chk_parity_like: assert property (@(posedge clk) disable iff (!reset_n)
    (s2_valid_q && s2_write_q) || !out_valid_q |-> !parity_lines_oe)
    else $error("parity lines driven outside a read data phase");

  chk_deselect_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (run && !start && !adv) ##1 run |=> !data_oe && !parity_lines_oe)
    else $error("driving after a deselect beat");

  chk_sleep_freeze: assert property (@(posedge clk) disable iff (!reset_n)
    sleeping_q |=> $stable(s1_valid_q) && $stable(count_q) && $stable(data_out))
    else $error("state changed while asleep");

  chk_strap_caught: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(mode_caught_q) |-> mode_q == $past(burst_order))
    else $error("burst order strap not caught");

  chk_stretch_keeps: assert property (@(posedge clk) disable iff (!reset_n)
    clock_qualify_n |=> $stable(active_q) && $stable(base_q) && $stable(write_hold_q))
    else $error("access state changed while stretched");

  chk_capture_phase: assert property (@(posedge clk) disable iff (!reset_n)
    (start && !write_n) ##1 run ##1 run |-> wr_lane == ~$past(lane_write_n, 2))
    else $error("write lanes not applied at second rise");

  cov_read: cover property (@(posedge clk) disable iff (!reset_n) start && write_n ##2 data_oe);
  cov_write: cover property (@(posedge clk) disable iff (!reset_n) start && !write_n);
  cov_burst: cover property (@(posedge clk) disable iff (!reset_n) adv [*3]);
  cov_sleep: cover property (@(posedge clk) disable iff (!reset_n) $rose(sleeping_q));
  cov_stall: cover property (@(posedge clk) disable iff (!reset_n) start ##1 clock_qualify_n [*3]);
endmodule : pbsp_port

// [pbsp_ctrl_model.sv]
// controller model: drives the port controls and resolves the shared data lines
`timescale 1ns/10ps
module pbsp_ctrl_model (
  // clock
  input  wire logic                        clk,
  // controls
  output logic                             clock_qualify_n,
  output logic                             select_a_n,
  output logic                             select_b,
  output logic                             select_c_n,
  output logic                             advance_or_load,
  output logic                             write_n,
  output logic [pbsp_pkg::LANES-1:0]       lane_write_n,
  output logic [pbsp_pkg::ADDR_W-1:0]      address,
  // shared lines
  output logic [pbsp_pkg::DATA_W-1:0]      data_in,
  output logic [pbsp_pkg::LANES-1:0]       parity_lines_in,
  input  wire logic [pbsp_pkg::DATA_W-1:0] data_out,
  input  wire logic                        data_oe,
  input  wire logic [pbsp_pkg::LANES-1:0]  parity_lines_out,
  input  wire logic                        parity_lines_oe
);
  logic        bus_en;
  logic [35:0] bus_w;
  logic [35:0] last_q = 36'h0;
  logic [1:0]  p_en;
  logic [35:0] p_w [2];
  logic        in_wr;

  // released lines toggle, so a stale value never passes for read data
  assign data_in = data_oe ? data_out : (bus_en ? bus_w[31:0] : ~last_q[31:0]);
  assign parity_lines_in = parity_lines_oe ? parity_lines_out
                                           : (bus_en ? bus_w[35:32] : ~last_q[35:32]);
  always @(posedge clk) last_q <= {parity_lines_in, data_in};

  initial begin
    {clock_qualify_n, select_a_n, select_b, select_c_n} = 4'h5;
    {advance_or_load, write_n, lane_write_n} = 6'h1f;
    address = 17'h0;
    bus_en = 1'b0;
    bus_w = 36'h0;
    p_en = 2'h0;
    in_wr = 1'b0;
  end

  task automatic cyc(input logic [2:0] s, input logic adv, input logic wn,
                     input logic [3:0] ln, input logic [16:0] a, input logic [35:0] wd);
    @(negedge clk);
    clock_qualify_n = 1'b0;
    {select_a_n, select_b, select_c_n} = s;
    advance_or_load = adv;
    write_n = wn;
    lane_write_n = ln;
    address = a;
    if (!adv) in_wr = (s == 3'h2) && !wn;
    // write data two beats after its address
    bus_en = p_en[1];
    bus_w = p_w[1];
    p_en[1] = p_en[0];
    p_w[1] = p_w[0];
    p_en[0] = in_wr;
    p_w[0] = wd;
    @(posedge clk);
    #1;
  endtask : cyc

  // stretch the beat; a write shown meanwhile must be ignored
  task automatic stall(input int n);
    @(negedge clk);
    clock_qualify_n = 1'b1;
    write_n = 1'b0;
    lane_write_n = 4'h0;
    address = 17'h0;
    repeat (n) @(posedge clk);
    #1;
  endtask : stall
endmodule : pbsp_ctrl_model

// [pbsp_port_test.sv]
// self-checking bench of the sram port against the controller model
`timescale 1ns/10ps
module pbsp_port_test;
  localparam logic [2:0] BAD [3] = '{3'h6, 3'h0, 3'h3};
  logic        clk;
  logic        reset_n;
  logic        output_enable_n;
  logic        sleep_request;
  logic        burst_order;
  logic        cq_n, sa_n, sb, sc_n, adv, wr_n, d_oe, p_oe, sleeping;
  logic [3:0]  lanes_n, p_in, p_out;
  logic [16:0] addr;
  logic [31:0] d_in, d_out;
  logic [35:0] w1;
  logic [35:0] exp5;
  int          n_fail;
  int          compares;

  pbsp_port pbsp_port_inst (.clk(clk), .reset_n(reset_n), .clock_qualify_n(cq_n),
    .select_a_n(sa_n), .select_b(sb), .select_c_n(sc_n), .advance_or_load(adv),
    .write_n(wr_n), .lane_write_n(lanes_n), .address(addr),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .burst_order(burst_order), .data_in(d_in), .data_out(d_out), .data_oe(d_oe),
    .parity_lines_in(p_in), .parity_lines_out(p_out), .parity_lines_oe(p_oe),
    .sleeping(sleeping));
  pbsp_ctrl_model pbsp_ctrl_model_inst (.clk(clk), .clock_qualify_n(cq_n),
    .select_a_n(sa_n), .select_b(sb), .select_c_n(sc_n), .advance_or_load(adv),
    .write_n(wr_n), .lane_write_n(lanes_n), .address(addr), .data_in(d_in),
    .parity_lines_in(p_in), .data_out(d_out), .data_oe(d_oe),
    .parity_lines_out(p_out), .parity_lines_oe(p_oe));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [35:0] word(input logic [16:0] a);
    return {~a[3:0], 15'h2a5c, a};
  endfunction : word

  task automatic idle();
    pbsp_ctrl_model_inst.cyc(3'h5, 1'b0, 1'b1, 4'hf, 17'h0, 36'h0);
  endtask : idle

  task automatic do_reset(input logic order);
    @(negedge clk);
    burst_order = order;
    reset_n = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    idle();
  endtask : do_reset

  task automatic wr(input logic [16:0] a, input logic [3:0] ln, input logic [35:0] d);
    pbsp_ctrl_model_inst.cyc(3'h2, 1'b0, 1'b0, ln, a, d);
    idle();
    check({35'h0, p_oe | d_oe}, 36'h0);
    idle();
  endtask : wr

  task automatic rd(input logic [16:0] a, input logic [35:0] exp, input logic oe);
    pbsp_ctrl_model_inst.cyc(3'h2, 1'b0, 1'b1, 4'hf, a, 36'h0);
    idle();
    check({34'h0, p_oe, d_oe}, {34'h0, oe, oe});
    if (oe) check({p_out, d_out}, exp);
    idle();
  endtask : rd

  task automatic s_write_read();
    w1 = word(17'h5);
    wr(17'h5, 4'h0, w1);
    rd(17'h5, w1, 1'b1);
    @(negedge clk);
    output_enable_n = 1'b1;
    pbsp_ctrl_model_inst.cyc(3'h2, 1'b0, 1'b1, 4'hf, 17'h5, 36'h0);
    idle();
    check({35'h0, d_oe}, 36'h0);
    // output enable acts without a clock edge, inside the read data phase
    @(negedge clk);
    output_enable_n = 1'b0;
    #1;
    check({d_oe, 3'h0, p_out, d_out}, {1'b1, 3'h0, w1});
    idle();
  endtask : s_write_read

  task automatic s_lanes();
    exp5 = (~w1 & {4'h5, 32'h00ff00ff}) | (w1 & {4'ha, 32'hff00ff00});
    wr(17'h5, 4'ha, ~w1);
    rd(17'h5, exp5, 1'b1);
  endtask : s_lanes

  task automatic s_freeze();
    pbsp_ctrl_model_inst.cyc(3'h2, 1'b0, 1'b1, 4'hf, 17'h5, 36'h0);
    pbsp_ctrl_model_inst.stall(3);
    check({35'h0, d_oe}, 36'h0);
    idle();
    check({d_oe, 3'h0, p_out, d_out}, {1'b1, 3'h0, exp5});
    idle();
  endtask : s_freeze

  task automatic s_deselect();
    foreach (BAD[i]) begin
      pbsp_ctrl_model_inst.cyc(BAD[i], 1'b0, 1'b1, 4'hf, 17'h5, 36'h0);
      idle();
      check({35'h0, d_oe}, 36'h0);
      idle();
    end
  endtask : s_deselect

  task automatic s_sleep();
    @(negedge clk);
    sleep_request = 1'b1;
    repeat (4) idle();
    check({35'h0, sleeping}, 36'h1);
    // sleep held low in normal operation
    @(negedge clk);
    sleep_request = 1'b0;
    repeat (4) idle();
    check({35'h0, sleeping}, 36'h0);
    rd(17'h5, exp5, 1'b1);
  endtask : s_sleep

  task automatic s_burst(input logic order);
    logic [16:0] a;
    do_reset(order);
    for (int k = 0; k < 4; k++) wr(17'h8 + 17'(k), 4'h0, word(17'h8 + 17'(k)));
    for (int i = 0; i < 6; i++) begin
      if (i >= 4) idle();
      else pbsp_ctrl_model_inst.cyc(3'h2, i != 0, 1'b1, 4'hf, 17'h9, 36'h0);
      a = 17'h8 + 17'(order ? ((i - 1) ^ 1) : (i % 4));
      if (i >= 1 && i <= 4) check({p_out, d_out}, word(a));
    end
  endtask : s_burst

  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    n_fail = 0;
    compares = 0;
    reset_n = 1'b0;
    output_enable_n = 1'b0;
    sleep_request = 1'b0;
    burst_order = 1'b0;
    do_reset(1'b0);
    s_write_read();
    s_lanes();
    s_freeze();
    s_deselect();
    s_sleep();
    s_burst(1'b0);
    s_burst(1'b1);
    report_and_stop();
  end

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
endmodule : pbsp_port_test
